/* include/dtf_pkg.sv */
// dtf_pkg: constants, field positions and carrier types of the disk task file block.
// assumes a parallel IDE host port on pins and a same-clock flash media engine behind it.
package dtf_pkg;

	// clock and soft reset recovery timing
	localparam int unsigned CLK_PERIOD_NS  = 20;
	localparam int unsigned RECOVER_NS     = 2000;
	localparam int unsigned RECOVER_CYCLES = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0]  RECOVER_LAST   = 8'(RECOVER_CYCLES - 1);

	// command block offsets (chip select 0 low)
	localparam logic [2:0] TF_DATA   = 3'h0;
	localparam logic [2:0] TF_ERROR  = 3'h1;
	localparam logic [2:0] TF_COUNT  = 3'h2;
	localparam logic [2:0] TF_SECTOR = 3'h3;
	localparam logic [2:0] TF_CYLLO  = 3'h4;
	localparam logic [2:0] TF_CYLHI  = 3'h5;
	localparam logic [2:0] TF_DRVHD  = 3'h6;
	localparam logic [2:0] TF_STATUS = 3'h7;
	// control block offsets (chip select 1 low)
	localparam logic [2:0] CB_ALTCTL = 3'h6;
	localparam logic [2:0] CB_DRVADR = 3'h7;

	// drive and head register fields
	localparam int unsigned DH_MODE  = 6;
	localparam int unsigned DH_DRIVE = 4;
	localparam logic [7:0]  DH_ONES  = 8'hA0;
	localparam logic [7:0]  DH_RESET = 8'hA0;

	// status bit positions
	localparam int unsigned ST_BUSY  = 7;
	localparam int unsigned ST_READY = 6;
	localparam int unsigned ST_WFLT  = 5;
	localparam int unsigned ST_SEEK  = 4;
	localparam int unsigned ST_DREQ  = 3;
	localparam int unsigned ST_FIXED = 2;
	localparam int unsigned ST_INDEX = 1;
	localparam int unsigned ST_ERR   = 0;
	localparam logic [7:0]  ST_BUSY_ONLY = 8'h80;

	// device control fields
	localparam int unsigned DC_RESET  = 2;
	localparam int unsigned DC_IRQOFF = 1;

	// error register values and readback masks
	localparam logic [7:0] ERR_RESET = 8'h01;
	localparam logic [7:0] ERR_ABORT = 8'h04;
	localparam logic [7:0] OE_ALL    = 8'hFF;
	localparam logic [7:0] OE_NO_TOP = 8'h7F;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	typedef struct packed {
		logic       cs1N;
		logic       cs0N;
		logic [2:0] addr;
		logic       iordN;
		logic       iowrN;
		logic [7:0] data;
	} dtf_host_t;

	typedef struct packed {
		logic       done;
		logic       error;
		logic [7:0] errCode;
		logic       writeFault;
		logic       corrected;
		logic       seekFound;
		logic       dataRequest;
		logic       ready;
		logic       irq;
	} dtf_media_t;

	typedef struct packed {
		logic        blockAddrMode;
		logic [3:0]  headField;
		logic [7:0]  sectorCount;
		logic [7:0]  sectorNumber;
		logic [7:0]  cylinderLow;
		logic [7:0]  cylinderHigh;
		logic [7:0]  feature;
		logic [27:0] blockAddress;
	} dtf_task_t;

	typedef enum logic [1:0] {
		DTF_RUN,
		DTF_HOLD,
		DTF_RECOVER
	} dtf_rst_state_t;

	// commands that need ready and seek complete before they are taken
	function automatic logic dtf_is_media_cmd(input logic [7:0] code);
		logic [3:0] hi;
		hi = code[7:4];
		dtf_is_media_cmd = (hi == 4'h2) || (hi == 4'h3) || (hi == 4'h4) || (hi == 4'h7)
			|| (code == 8'hC4) || (code == 8'hC5) || (code == 8'hCD);
	endfunction : dtf_is_media_cmd

endpackage : dtf_pkg

/* hw/dtf_pin_sync.sv */
// dtf_pin_sync: three-stage pin synchroniser with an agreement filter per bit.
// assumes inputs are asynchronous to clk_sys; output moves only when stages two and three agree.
`timescale 1ns/100ps
module dtf_pin_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk_sys,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinOut
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic s1_r;
			logic s2_r;
			logic s3_r;
			// stage one feeds only stage two
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					s1_r        <= 1'b1;
					s2_r        <= 1'b1;
					s3_r        <= 1'b1;
					pinOut[i]   <= 1'b1;
				end else begin
					s1_r <= pinIn[i];
					s2_r <= s1_r;
					s3_r <= s2_r;
					if (s2_r == s3_r) begin
						pinOut[i] <= s3_r;
					end
				end
			end
		end
	endgenerate

endmodule : dtf_pin_sync

/* hw/dtf_task_file.sv */
// dtf_task_file: host-visible task file, status, device control and drive address registers.
// assumes the host pins are asynchronous and the media engine runs on clk_sys.
//
// Notes on behaviour
// [RQ1]: drive/head bit 6 clear selects cylinder-head-sector, set selects block addressing.
// [RQ2]: block address is head field, cylinder high, cylinder low, sector number.
// [RQ3]: low four drive/head bits hold head number, or block address bits 27:24.
// [RQ4]: drive/head bit 4 picks the drive; answer only when it matches the strap.
// [RQ5]: busy at status bit 7 while working; other status bits then masked.
// [RQ6]: reading primary status clears the pending host interrupt.
// [RQ7]: media commands taken only when ready and seek complete are both set.
// [RQ8]: after an error ready stays frozen until the host reads status.
// [RQ9]: write fault at status bit 5 is set on a fault while writing.
// [RQ10]: seek complete at status bit 4 is set once the sector is found.
// [RQ11]: data request at status bit 3 shows a word may move now.
// [RQ12]: corrected flag at status bit 2 is set after a repaired data error.
// [RQ13]: index flag at status bit 1 always reads zero.
// [RQ14]: error at status bit 0 marks a failed command; detail in error register.
// [RQ15]: alternate status reads like status but leaves the interrupt pending.
// [RQ16]: host loads parameters first; writing the command code starts execution.
// [RQ17]: writing one to device control bit 2 forces a soft reset.
// [RQ18]: device control bit 1 low drives the interrupt line; else line floats.
// [RQ19]: host writes control bit 0 as zero, bit 3 as one; bits 7-4 ignored.
// [RQ20]: drive address bits 5-2 return the inverted head field; bit 7 undriven.
// [RQ21]: drive address bits 1 and 0 read low when drive 1 or 0 selected.
// [RQ22]: host should keep the drive address register out of its I/O map.
// [RQ23]: error register is valid only while busy reads zero.
// [RQ24]: drive/head bits 7 and 5 always read back as one.
// [RQ25]: soft reset held while bit stays one; busy recovery starts when cleared.
`timescale 1ns/100ps
module dtf_task_file
	import dtf_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire dtf_host_t   hostPins,
	input  wire logic        driveNumberStrap,
	input  wire dtf_media_t  media,
	output logic      [7:0]  hostDataOut,
	output logic      [7:0]  hostDataOe,
	output logic             hostInterruptLine,
	output logic             hostInterruptLineOe,
	output logic             cmdStart,
	output logic      [7:0]  cmdCode,
	output dtf_task_t        taskFile,
	output logic             softResetActive
);

	dtf_host_t      bus;
	dtf_host_t      busPrev_r;
	logic           strapSync;
	dtf_rst_state_t rstState_r;
	logic [7:0]     recoverCnt_r;

	logic [7:0] driveHeadSelect_r;
	logic [7:0] sectorCount_r;
	logic [7:0] sectorNumber_r;
	logic [7:0] cylinderLow_r;
	logic [7:0] cylinderHigh_r;
	logic [7:0] feature_r;
	logic [7:0] errorReg_r;
	logic       softResetBit_r;
	logic       interruptDisableBit_r;

	logic busyFlag_r;
	logic readyFlag_r;
	logic readyHold_r;
	logic writeFaultFlag_r;
	logic seekCompleteFlag_r;
	logic dataRequestFlag_r;
	logic correctedFlag_r;
	logic errorFlag_r;
	logic irqPend_r;

	logic       selected;
	logic       taskSel;
	logic       ctrlSel;
	logic       prevTaskSel;
	logic       prevCtrlSel;
	logic       wrDone;
	logic       rdDone;
	logic       cmdWrite;
	logic       cmdAbort;
	logic       cmdGo;
	logic       recoverEnd;
	logic       statusRead;
	logic       errorEvent;
	logic [7:0] commandStatus;
	logic [7:0] statusShadowNoclear;
	logic [7:0] driveSelectReadback;
	logic [7:0] rdMux;
	logic [7:0] rdOe;

	// pins are asynchronous; one filtered copy feeds all decode
	dtf_pin_sync #(.WIDTH($bits(dtf_host_t))) u_bus_sync (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.pinIn   (hostPins),
		.pinOut  (bus)
	);

	dtf_pin_sync #(.WIDTH(1)) u_strap_sync (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.pinIn   (driveNumberStrap),
		.pinOut  (strapSync)
	);

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			busPrev_r <= '1;
		end else begin
			busPrev_r <= bus;
		end
	end

	// strobe ends carry the side effects, so read data is served before any clear
	always_comb begin
		selected    = (driveHeadSelect_r[DH_DRIVE] == strapSync);            // [RQ4]
		taskSel     = !bus.cs0N && bus.cs1N;
		ctrlSel     = bus.cs0N && !bus.cs1N;
		prevTaskSel = !busPrev_r.cs0N && busPrev_r.cs1N;
		prevCtrlSel = busPrev_r.cs0N && !busPrev_r.cs1N;
		wrDone      = !busPrev_r.iowrN && bus.iowrN;
		rdDone      = !busPrev_r.iordN && bus.iordN;
		statusRead  = rdDone && prevTaskSel && selected
			&& (busPrev_r.addr == TF_STATUS);
		cmdWrite    = wrDone && prevTaskSel && selected
			&& (busPrev_r.addr == TF_STATUS) && !busyFlag_r
			&& (rstState_r == DTF_RUN);                                      // [RQ16]
		cmdAbort    = cmdWrite && dtf_is_media_cmd(busPrev_r.data)
			&& !(readyFlag_r && seekCompleteFlag_r);                         // [RQ7]
		cmdGo       = cmdWrite && !cmdAbort;
		recoverEnd  = (rstState_r == DTF_RECOVER) && (recoverCnt_r == RECOVER_LAST);
		errorEvent  = (busyFlag_r && media.error) || cmdAbort;
	end

	// task file parameter registers; writes land in both drives as on a shared cable
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			driveHeadSelect_r <= DH_RESET;
			sectorCount_r     <= BYTE_ZERO;
			sectorNumber_r    <= BYTE_ZERO;
			cylinderLow_r     <= BYTE_ZERO;
			cylinderHigh_r    <= BYTE_ZERO;
			feature_r         <= BYTE_ZERO;
		end else if (wrDone && prevTaskSel && !busyFlag_r) begin
			unique case (busPrev_r.addr)
				TF_ERROR:  feature_r         <= busPrev_r.data;
				TF_COUNT:  sectorCount_r     <= busPrev_r.data;
				TF_SECTOR: sectorNumber_r    <= busPrev_r.data;
				TF_CYLLO:  cylinderLow_r     <= busPrev_r.data;
				TF_CYLHI:  cylinderHigh_r    <= busPrev_r.data;
				TF_DRVHD:  driveHeadSelect_r <= busPrev_r.data | DH_ONES;   // [RQ24]
				default:   driveHeadSelect_r <= driveHeadSelect_r;
			endcase
		end
	end

	// device control: only reset and interrupt disable are kept
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			softResetBit_r        <= 1'b0;
			interruptDisableBit_r <= 1'b0;
		end else if (wrDone && prevCtrlSel && (busPrev_r.addr == CB_ALTCTL)) begin
			softResetBit_r        <= busPrev_r.data[DC_RESET];                // [RQ17]
			interruptDisableBit_r <= busPrev_r.data[DC_IRQOFF];               // [RQ18]
		end
	end

	// soft reset sequencing: hold while the bit is one, fixed recovery after
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rstState_r   <= DTF_RUN;
			recoverCnt_r <= BYTE_ZERO;
		end else begin
			unique case (rstState_r)
				DTF_RUN: begin
					if (softResetBit_r) begin
						rstState_r <= DTF_HOLD;                              // [RQ17]
					end
				end
				DTF_HOLD: begin
					recoverCnt_r <= BYTE_ZERO;
					if (!softResetBit_r) begin
						rstState_r <= DTF_RECOVER;                           // [RQ25]
					end
				end
				DTF_RECOVER: begin
					if (softResetBit_r) begin
						rstState_r <= DTF_HOLD;
					end else if (recoverEnd) begin
						rstState_r <= DTF_RUN;
					end else begin
						recoverCnt_r <= recoverCnt_r + 8'h01;
					end
				end
			endcase
		end
	end

	// busy: a command or a soft reset in progress
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			busyFlag_r <= 1'b0;
		end else if (rstState_r != DTF_RUN) begin
			busyFlag_r <= !recoverEnd;                                       // [RQ25]
		end else if (softResetBit_r) begin
			busyFlag_r <= 1'b1;
		end else if (cmdGo) begin
			busyFlag_r <= 1'b1;                                              // [RQ5]
		end else if (media.done || media.error) begin
			busyFlag_r <= 1'b0;
		end
	end

	// ready follows the media unless an error froze it; status read releases it
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			readyHold_r <= 1'b0;
			readyFlag_r <= 1'b1;
		end else if (rstState_r != DTF_RUN) begin
			readyHold_r <= 1'b0;
			readyFlag_r <= recoverEnd;
		end else begin
			if (errorEvent) begin
				readyHold_r <= 1'b1;                                         // [RQ8]
			end else if (statusRead) begin
				readyHold_r <= 1'b0;
			end
			if (!readyHold_r && !errorEvent) begin
				readyFlag_r <= media.ready;                                  // [RQ8]
			end
		end
	end

	// command-scoped flags clear at start; media events set them
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			writeFaultFlag_r   <= 1'b0;
			seekCompleteFlag_r <= 1'b1;
			correctedFlag_r    <= 1'b0;
			errorFlag_r        <= 1'b0;
		end else if (rstState_r != DTF_RUN) begin
			writeFaultFlag_r   <= 1'b0;
			seekCompleteFlag_r <= recoverEnd;
			correctedFlag_r    <= 1'b0;
			errorFlag_r        <= 1'b0;
		end else if (cmdWrite) begin
			writeFaultFlag_r   <= 1'b0;
			seekCompleteFlag_r <= cmdAbort && seekCompleteFlag_r;
			correctedFlag_r    <= 1'b0;
			errorFlag_r        <= cmdAbort;                                  // [RQ14]
		end else begin
			if (media.writeFault) begin
				writeFaultFlag_r <= 1'b1;                                    // [RQ9]
			end
			if (media.seekFound || media.done) begin
				seekCompleteFlag_r <= 1'b1;                                  // [RQ10]
			end
			if (media.corrected) begin
				correctedFlag_r <= 1'b1;                                     // [RQ12]
			end
			if (busyFlag_r && media.error) begin
				errorFlag_r <= 1'b1;                                         // [RQ14]
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			dataRequestFlag_r <= 1'b0;
		end else begin
			dataRequestFlag_r <= media.dataRequest && (rstState_r == DTF_RUN); // [RQ11]
		end
	end

	// error detail; diagnostic pass code after any reset
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			errorReg_r <= ERR_RESET;
		end else if (recoverEnd) begin
			errorReg_r <= ERR_RESET;
		end else if (cmdAbort) begin
			errorReg_r <= ERR_ABORT;                                         // [RQ14]
		end else if (cmdGo) begin
			errorReg_r <= BYTE_ZERO;
		end else if (busyFlag_r && media.error) begin
			errorReg_r <= media.errCode;                                     // [RQ14]
		end
	end

	// pending interrupt: a new event in the clearing cycle wins over the read
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			irqPend_r <= 1'b0;
		end else if (media.irq || errorEvent || (busyFlag_r && media.done) || recoverEnd) begin
			irqPend_r <= 1'b1;
		end else if (statusRead || softResetBit_r) begin
			irqPend_r <= 1'b0;                                               // [RQ6]
		end
	end

	// the line floats when disabled or deselected so the other drive can own it
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			hostInterruptLine   <= 1'b1;
			hostInterruptLineOe <= 1'b0;
		end else begin
			hostInterruptLine   <= !irqPend_r;
			hostInterruptLineOe <= !interruptDisableBit_r && selected;       // [RQ18]
		end
	end

	// readback values
	always_comb begin
		commandStatus = BYTE_ZERO;
		commandStatus[ST_BUSY]  = busyFlag_r;
		commandStatus[ST_READY] = readyFlag_r;
		commandStatus[ST_WFLT]  = writeFaultFlag_r;
		commandStatus[ST_SEEK]  = seekCompleteFlag_r;
		commandStatus[ST_DREQ]  = dataRequestFlag_r;
		commandStatus[ST_FIXED] = correctedFlag_r;
		commandStatus[ST_INDEX] = 1'b0;                                      // [RQ13]
		commandStatus[ST_ERR]   = errorFlag_r;
		if (busyFlag_r) begin
			commandStatus = ST_BUSY_ONLY;                                    // [RQ5]
		end
		statusShadowNoclear = commandStatus;                                 // [RQ15]
		driveSelectReadback = {1'b0, 1'b1, ~driveHeadSelect_r[3:0],
			!(selected && strapSync), !(selected && !strapSync)};            // [RQ20] [RQ21]
	end

	// read mux; the data port itself belongs to the transfer engine and is not driven here
	always_comb begin
		rdMux = BYTE_ZERO;
		rdOe  = BYTE_ZERO;
		if (!bus.iordN && selected) begin
			if (taskSel && (bus.addr != TF_DATA)) begin
				rdOe = OE_ALL;
				unique case (bus.addr)
					TF_ERROR:  rdMux = errorReg_r;                           // [RQ23]
					TF_COUNT:  rdMux = sectorCount_r;
					TF_SECTOR: rdMux = sectorNumber_r;
					TF_CYLLO:  rdMux = cylinderLow_r;
					TF_CYLHI:  rdMux = cylinderHigh_r;
					TF_DRVHD:  rdMux = driveHeadSelect_r;                    // [RQ3]
					TF_STATUS: rdMux = commandStatus;
					default:   rdMux = BYTE_ZERO;
				endcase
			end else if (ctrlSel && (bus.addr == CB_ALTCTL)) begin
				rdOe  = OE_ALL;
				rdMux = statusShadowNoclear;                                 // [RQ15]
			end else if (ctrlSel && (bus.addr == CB_DRVADR)) begin
				rdOe  = OE_NO_TOP;                                           // [RQ20]
				rdMux = driveSelectReadback;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			hostDataOut <= BYTE_ZERO;
			hostDataOe  <= BYTE_ZERO;
		end else begin
			hostDataOut <= rdMux;
			hostDataOe  <= rdOe;
		end
	end

	// media side: one-cycle start with the code, registered task file view
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cmdStart <= 1'b0;
			cmdCode  <= BYTE_ZERO;
		end else begin
			cmdStart <= cmdGo;                                               // [RQ16]
			if (cmdGo) begin
				cmdCode <= busPrev_r.data;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			taskFile        <= '0;
			softResetActive <= 1'b0;
		end else begin
			taskFile.blockAddrMode <= driveHeadSelect_r[DH_MODE];            // [RQ1]
			taskFile.headField     <= driveHeadSelect_r[3:0];                // [RQ3]
			taskFile.sectorCount   <= sectorCount_r;
			taskFile.sectorNumber  <= sectorNumber_r;
			taskFile.cylinderLow   <= cylinderLow_r;
			taskFile.cylinderHigh  <= cylinderHigh_r;
			taskFile.feature       <= feature_r;
			taskFile.blockAddress  <= driveHeadSelect_r[DH_MODE]
				? {driveHeadSelect_r[3:0], cylinderHigh_r, cylinderLow_r, sectorNumber_r}
				: 28'h0000000;                                               // [RQ2]
			softResetActive        <= (rstState_r != DTF_RUN);               // [RQ25]
		end
	end

endmodule : dtf_task_file

/* sim/dtf_task_file_props.sv */
// dtf_task_file_props: port-level assertions of the task file block.
// assumes address and selects held until read data drops.
`timescale 1ns/100ps
module dtf_task_file_props
	import dtf_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       reset_n,
	input wire dtf_host_t  hostPins,
	input wire logic       driveNumberStrap,
	input wire logic [7:0] hostDataOut,
	input wire logic [7:0] hostDataOe,
	input wire logic       hostInterruptLine,
	input wire logic       hostInterruptLineOe,
	input wire logic       cmdStart,
	input wire dtf_task_t  taskFile,
	input wire logic       softResetActive
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	logic       cmdRd, rdStat, rdDh, rdAdr;
	logic [7:0] srCnt_r;
	assign cmdRd  = !hostPins.cs0N && hostPins.cs1N && |hostDataOe;
	assign rdStat = cmdRd && hostPins.addr == TF_STATUS;
	assign rdDh   = cmdRd && hostPins.addr == TF_DRVHD;
	assign rdAdr  = !hostPins.cs1N && hostPins.cs0N && hostPins.addr == CB_DRVADR
		&& |hostDataOe;
	// saturating count of cycles spent in soft reset
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			srCnt_r <= 8'h00;
		else if (!softResetActive)
			srCnt_r <= 8'h00;
		else if (srCnt_r != 8'hFF)
			srCnt_r <= srCnt_r + 8'h01;
	end
	idx_zero_a: assert property (rdStat |-> !hostDataOut[ST_INDEX])
		else $error("index set");
	busy_mask_a: assert property (rdStat && hostDataOut[ST_BUSY] |-> hostDataOut == ST_BUSY_ONLY)
		else $error("busy not masked");
	dh_ones_a: assert property (rdDh |-> hostDataOut[7] && hostDataOut[5])
		else $error("fixed ones lost");
	adr_head_a: assert property (rdAdr |-> hostDataOe == OE_NO_TOP
		&& hostDataOut[5:2] == ~taskFile.headField) else $error("drive address head wrong");
	adr_sel_a: assert property (rdAdr |-> hostDataOut[1:0] == {!driveNumberStrap, driveNumberStrap})
		else $error("select readback");
	lba_build_a: assert property (taskFile.blockAddrMode |-> taskFile.blockAddress ==
		{taskFile.headField, taskFile.cylinderHigh, taskFile.cylinderLow, taskFile.sectorNumber})
		else $error("block address");
	chs_zero_a: assert property (!taskFile.blockAddrMode |-> taskFile.blockAddress == 28'h0000000)
		else $error("address not zero");
	start_pulse_a: assert property (cmdStart |=> !cmdStart)
		else $error("start too long");
	soft_reset_bit_block_a: assert property (softResetActive |-> !cmdStart)
		else $error("start in reset");
	soft_reset_bit_len_a: assert property ($fell(softResetActive) |-> srCnt_r >= RECOVER_LAST)
		else $error("recovery short");
	irq_drive_a: assert property ($fell(hostInterruptLine) |-> hostInterruptLineOe)
		else $error("irq while floated");
	cover property (cmdStart);
	cover property ($fell(hostInterruptLine));
	cover property ($fell(softResetActive));
	cover property (rdAdr);
endmodule : dtf_task_file_props

/* sim/dtf_media_model.sv */
// dtf_media_model: behavioural flash engine behind the task file.
// assumes one command at a time; outcome chosen by the bench before the command.
`timescale 1ns/100ps
module dtf_media_model
	import dtf_pkg::*;
#(
	parameter int unsigned DELAY = 60
) (
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	input  wire logic       cmdStart,
	input  wire logic [1:0] outcome,
	input  wire logic       readyLevel,
	input  wire logic       dataReqLevel,
	output dtf_media_t      media
);
	logic [7:0] waitCnt_r;
	logic       active_r;
	logic       fire;
	assign fire = active_r && waitCnt_r == 8'h00;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			active_r  <= 1'b0;
			waitCnt_r <= 8'h00;
		end else if (cmdStart) begin
			active_r  <= 1'b1;
			waitCnt_r <= 8'(DELAY);
		end else if (fire)
			active_r <= 1'b0;
		else if (active_r)
			waitCnt_r <= waitCnt_r - 8'h01;
	end
	// outcome 0 clean, 1 error, 2 write fault with corrected data
	always_comb begin
		media             = '0;
		media.ready       = readyLevel;
		media.dataRequest = dataReqLevel;
		media.seekFound   = fire;
		media.done        = fire && outcome != 2'h1;
		media.error       = fire && outcome == 2'h1;
		media.errCode     = media.error ? 8'h10 : 8'h00;
		media.writeFault  = fire && outcome == 2'h2;
		media.corrected   = fire && outcome == 2'h2;
	end
endmodule : dtf_media_model

/* sim/testbench.sv */
// testbench: host pin driver for the task file, media model behind it.
// assumes write strobes held 5 clocks and read strobes 8 clocks so the pin filter passes them.
`timescale 1ns/100ps
module testbench
	import dtf_pkg::*;
;
	logic       clk_sys, reset_n, strap, readyLevel, dataReqLevel, irqLine, irqOe;
	logic       cmdStart, srstAct, startSeen;
	logic [1:0] outcome;
	dtf_host_t  pins;
	dtf_media_t media;
	logic [7:0] dOut, dOe, cmdCode, rdData, rdOe, codeSeen;
	dtf_task_t  taskFile;
	logic [7:0] expSt [3] = '{8'h50, 8'h51, 8'h7C};
	int         n_errors = 0;
	int         tests_run = 0;

	dtf_task_file dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .hostPins(pins),
		.driveNumberStrap(strap), .media(media), .hostDataOut(dOut), .hostDataOe(dOe),
		.hostInterruptLine(irqLine), .hostInterruptLineOe(irqOe), .cmdStart(cmdStart),
		.cmdCode(cmdCode), .taskFile(taskFile), .softResetActive(srstAct));
	dtf_media_model media_u (.clk_sys(clk_sys), .reset_n(reset_n),
		.cmdStart(cmdStart), .outcome(outcome), .readyLevel(readyLevel),
		.dataReqLevel(dataReqLevel), .media(media));

	task automatic report_and_stop;
		$display("compares %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	task automatic fail;
		n_errors++;
		report_and_stop();
	endtask : fail
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask : tick
	task automatic io_wr(input logic ctl, input logic [2:0] a, input logic [7:0] d);
		pins.cs1N = !ctl;
		pins.cs0N = ctl;
		pins.addr = a;
		pins.data = d;
		tick(1);
		pins.iowrN = 1'b0;
		tick(5);
		pins.iowrN = 1'b1;
		startSeen = 1'b0;
		// outputs settled at negedge
		repeat (8) begin
			@(negedge clk_sys);
			if (cmdStart === 1'b1) begin
				startSeen = 1'b1;
				codeSeen = cmdCode;
			end
		end
		tick(1);
		pins.cs0N = 1'b1;
		pins.cs1N = 1'b1;
	endtask : io_wr
	task automatic io_rd(input logic ctl, input logic [2:0] a);
		pins.cs1N = !ctl;
		pins.cs0N = ctl;
		pins.addr = a;
		tick(1);
		pins.iordN = 1'b0;
		tick(8);
		rdData = dOut;
		rdOe = dOe;
		pins.iordN = 1'b1;
		// hold address until oe drops
		for (int i = 0; i < 12 && dOe != 8'h00; i++)
			tick(1);
		if (dOe !== 8'h00)
			fail();
		tick(2);
		pins.cs0N = 1'b1;
		pins.cs1N = 1'b1;
	endtask : io_rd
	task automatic rd_chk(input logic ctl, input logic [2:0] a, input logic [7:0] m,
		input logic [7:0] e);
		io_rd(ctl, a);
		check(rdData & m, e);
	endtask : rd_chk
	task automatic wait_irq;
		for (int i = 0; i < 120 && irqLine !== 1'b0; i++)
			tick(1);
		if (irqLine !== 1'b0)
			fail();
	endtask : wait_irq

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		#1500000;
		fail();
	end
	initial begin
		reset_n = 1'b0;
		pins = 15'h6300;
		strap = 1'b0;
		outcome = 2'h0;
		readyLevel = 1'b1;
		dataReqLevel = 1'b0;
		repeat (12) @(posedge clk_sys);
		#2;
		reset_n = 1'b1;
		tick(10);
		rd_chk(1'b0, TF_STATUS, 8'hFF, 8'h50);
		rd_chk(1'b0, TF_ERROR, 8'hFF, ERR_RESET);
		$display("test reset values done");
		io_wr(1'b0, TF_SECTOR, 8'h11);
		io_wr(1'b0, TF_CYLLO, 8'h22);
		io_wr(1'b0, TF_CYLHI, 8'h33);
		io_wr(1'b0, TF_DRVHD, 8'h45);
		rd_chk(1'b0, TF_DRVHD, 8'hFF, 8'hE5);
		check(taskFile.blockAddress, 32'h05332211);
		io_wr(1'b0, TF_DRVHD, 8'h03);
		check({taskFile.blockAddrMode, taskFile.headField}, 32'h03);
		rd_chk(1'b1, CB_DRVADR, 8'h7F, 8'h72);
		check(rdOe, OE_NO_TOP);
		$display("test addressing done");
		for (int k = 0; k < 3; k++) begin
			outcome = 2'(k);
			dataReqLevel = (k == 2);
			io_wr(1'b0, TF_STATUS, 8'h30);
			check(startSeen, 1'b1);
			check(codeSeen, 8'h30);
			rd_chk(1'b1, CB_ALTCTL, 8'hFF, ST_BUSY_ONLY);
			wait_irq();
			rd_chk(1'b1, CB_ALTCTL, 8'hFF, expSt[k]);
			check(irqLine, 1'b0);
			if (k == 1)
				rd_chk(1'b0, TF_ERROR, 8'hFF, 8'h10);
			rd_chk(1'b0, TF_STATUS, 8'hFF, expSt[k]);
			check(irqLine, 1'b1);
		end
		$display("test command outcomes done");
		outcome = 2'h1;
		dataReqLevel = 1'b0;
		io_wr(1'b0, TF_STATUS, 8'h30);
		wait_irq();
		readyLevel = 1'b0;
		rd_chk(1'b1, CB_ALTCTL, 8'hFF, 8'h51);
		rd_chk(1'b0, TF_STATUS, 8'hFF, 8'h51);
		rd_chk(1'b1, CB_ALTCTL, 8'hFF, 8'h11);
		io_wr(1'b0, TF_STATUS, 8'h20);
		check(startSeen, 1'b0);
		rd_chk(1'b0, TF_ERROR, 8'hFF, ERR_ABORT);
		readyLevel = 1'b1;
		rd_chk(1'b0, TF_STATUS, 8'h01, 8'h01);
		$display("test error and refusal done");
		io_wr(1'b1, CB_ALTCTL, 8'h0A);
		check(irqOe, 1'b0);
		io_wr(1'b1, CB_ALTCTL, 8'h08);
		check(irqOe, 1'b1);
		io_wr(1'b0, TF_DRVHD, 8'hB0);
		check(irqOe, 1'b0);
		io_rd(1'b0, TF_STATUS);
		check(rdOe, 8'h00);
		io_wr(1'b0, TF_STATUS, 8'h30);
		check(startSeen, 1'b0);
		io_wr(1'b0, TF_DRVHD, 8'hA0);
		$display("test selection done");
		io_wr(1'b1, CB_ALTCTL, 8'h0C);
		check(srstAct, 1'b1);
		io_wr(1'b0, TF_STATUS, 8'h30);
		check(startSeen, 1'b0);
		rd_chk(1'b0, TF_STATUS, 8'hFF, ST_BUSY_ONLY);
		io_wr(1'b1, CB_ALTCTL, 8'h08);
		check(srstAct, 1'b1);
		for (int i = 0; i < 200 && srstAct !== 1'b0; i++)
			tick(1);
		if (srstAct !== 1'b0)
			fail();
		rd_chk(1'b0, TF_STATUS, 8'hFF, 8'h50);
		rd_chk(1'b0, TF_ERROR, 8'hFF, ERR_RESET);
		$display("test soft reset done");
		report_and_stop();
	end
endmodule : testbench

bind dtf_task_file dtf_task_file_props chk_u (.clk_sys(clk_sys), .reset_n(reset_n),
	.hostPins(hostPins), .driveNumberStrap(driveNumberStrap), .hostDataOut(hostDataOut),
	.hostDataOe(hostDataOe), .hostInterruptLine(hostInterruptLine),
	.hostInterruptLineOe(hostInterruptLineOe), .cmdStart(cmdStart), .taskFile(taskFile),
	.softResetActive(softResetActive));
